// ==== inc/rcs_pkg.sv ====
package rcs_pkg;
  // Configuration word placement and field positions
  localparam logic [13:0] CFG_ADDR = 14'h2007;
  localparam logic [13:0] CFG_SPACE_LO = 14'h2000;
  localparam logic [13:0] CFG_SPACE_HI = 14'h3fff;
  localparam int TRIM_HI = 13;
  localparam int TRIM_LO = 12;
  localparam int EEPROM_LOCK_BIT = 8;
  localparam int PROGRAM_LOCK_BIT = 7;
  localparam int BROWNOUT_EN_BIT = 6;
  localparam int RESET_PIN_SEL_BIT = 5;
  localparam int POWERUP_EN_N_BIT = 4;
  localparam int WATCHDOG_EN_BIT = 3;
  localparam int CLK_SEL_HI = 2;
  // Implemented bits of the configuration word, unprogrammed value
  localparam logic [13:0] CFG_IMPL_MASK = 14'h31ff;
  localparam logic [13:0] CFG_RESET = 14'h31ff;
  // Power status register
  localparam logic [7:0] PWR_STATUS_ADDR = 8'h8e;
  localparam int BROWNOUT_FLAG_BIT = 0;
  localparam int POWERON_FLAG_BIT = 1;
  // Clock source codes
  localparam logic [2:0] CLK_RC_QUARTER_CLOCK_OUT = 3'h7;
  localparam logic [2:0] CLK_RC_IO = 3'h6;
  localparam logic [2:0] CLK_INTERNAL_OSC_MODE_QUARTER_CLOCK_OUT = 3'h5;
  localparam logic [2:0] CLK_CODE_4 = 3'h4;
  localparam logic [2:0] CLK_EXT = 3'h3;
  localparam logic [2:0] CLK_FAST_XTAL = 3'h2;
  localparam logic [2:0] CLK_XTAL = 3'h1;
  localparam logic [2:0] CLK_CODE_0 = 3'h0;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int POWERUP_DELAY_MS = 72;
  localparam longint POWERUP_CYCLES_L = longint'(POWERUP_DELAY_MS) * CLK_HZ / 1000;
  localparam int POWERUP_CYCLES = int'(POWERUP_CYCLES_L);
  localparam int OSC_SETTLE_CYCLES = 1024;
endpackage : rcs_pkg

// ==== inc/tmr_if.sv ====
`timescale 1ns/1ps
interface tmr_if #(parameter int W = 22);
  logic start;
  logic [W-1:0] load;
  logic done;
  modport ctrl (output start, output load, input done);
  modport cnt (input start, input load, output done);
endinterface : tmr_if

// ==== rtl/delay_counter.sv ====
`timescale 1ns/1ps
// Down counter: start loads, done is a level once it reaches zero; clear restarts idle
module delay_counter #(parameter int W = 22) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, low
  input wire logic clear, // Abort count
  tmr_if.cnt t // Start, load, done
);
  logic [W-1:0] count_reg;
  logic run_reg;
  // Counting state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      run_reg <= 1'b0;
    end else if (clear) begin
      run_reg <= 1'b0;
    end else if (t.start) begin
      count_reg <= t.load;
      run_reg <= 1'b1;
    end else if (run_reg && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end
  assign t.done = run_reg && (count_reg == '0);
endmodule : delay_counter

// ==== rtl/reset_config_sequencer.sv ====
`timescale 1ns/1ps
module reset_config_sequencer
  import rcs_pkg::*;
#(
  parameter int POWERUP_CNT = POWERUP_CYCLES, // Power-up delay in cycles
  parameter int OSC_SETTLE_CNT = OSC_SETTLE_CYCLES, // Oscillator settle count
  parameter bit CODE4_IS_INTERNAL_OSC_MODE = 1'b1, // Code 100 treated as internal oscillator
  parameter bit CODE0_IS_XTAL = 1'b1 // Code 000 treated as low-power crystal
) (
  input wire logic CLK, // System clock
  input wire logic RSTN, // Power-on reset, low
  input wire logic PROG_MODE, // Programming mode pin
  input wire logic PROG_WR, // Programmer write strobe
  input wire logic PROG_RD, // Programmer read strobe
  input wire logic [13:0] PROG_ADDR, // Programmer address
  input wire logic [13:0] PROG_WDATA, // Programmer write data
  input wire logic BROWNOUT_DETECT, // Supply below threshold, high
  input wire logic EXT_RESET_PIN_N, // Shared reset pin, low active
  input wire logic REG_WR, // Core register write
  input wire logic [7:0] REG_ADDR, // Core register address
  input wire logic [7:0] REG_WDATA, // Core write data
  output logic [13:0] PROG_RDATA, // Programmer read data
  output logic [7:0] REG_RDATA, // Core read data
  output logic CORE_RESET_N, // Device reset, low
  output logic OSC_ENABLE, // Internal oscillator run
  output logic [1:0] BANDGAP_TRIM, // Threshold trim
  output logic BROWNOUT_ENABLE, // Detector on
  output logic WATCHDOG_ENABLE, // Watchdog on
  output logic [2:0] CLOCK_SOURCE_SEL, // Oscillator select
  output logic QUARTER_CLOCK_OUT_EN, // Clock out function on pin
  output logic EEPROM_PROTECT, // Data protection active
  output logic PROGRAM_PROTECT, // Program protection active
  output logic EEPROM_ERASE, // Pulse: erase data EEPROM
  output logic PROGRAM_ERASE // Pulse: erase program memory and trim
);
  localparam int TW = 22;
  typedef enum logic [4:0] {
    ST_POR = 5'h01,
    ST_BROWNOUT = 5'h02,
    ST_POWERUP = 5'h04,
    ST_SETTLE = 5'h08,
    ST_RUN = 5'h10
  } seq_e;
  seq_e state_reg, state_next;
  logic [13:0] cfg_reg;
  logic brownout_flag_reg;
  logic poweron_flag_reg;
  logic bo_m, bo_s;
  logic pin_m, pin_s;
  logic pm_m, pm_s;
  logic [1:0] bandgap_trim;
  logic eeprom_lock_n, program_lock_n, brownout_enable;
  logic reset_pin_sel, powerup_delay_en_n, watchdog_enable;
  logic brownout_reset_reg;
  logic ext_reset;
  logic cfg_hit, pwr_wr;
  logic [2:0] clk_sel;
  logic xtal_mode, intrc_mode, ext_clk_mode, delay_en, settle_needed;
  logic [13:0] cfg_wdata;
  tmr_if #(.W(TW)) pu_t ();
  tmr_if #(.W(TW)) os_t ();
  // Two-flop synchroniser for the supply monitor
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      bo_m <= 1'b0;
      bo_s <= 1'b0;
    end else begin
      bo_m <= BROWNOUT_DETECT;
      bo_s <= bo_m;
    end
  end
  // Two-flop synchroniser for the reset pin; idles high so no false reset follows power-on
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_m <= 1'b1;
      pin_s <= 1'b1;
    end else begin
      pin_m <= EXT_RESET_PIN_N;
      pin_s <= pin_m;
    end
  end
  // Two-flop synchroniser for the programming mode pin
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pm_m <= 1'b0;
      pm_s <= 1'b0;
    end else begin
      pm_m <= PROG_MODE;
      pm_s <= pm_m;
    end
  end
  // Named fields of the configuration word
  assign bandgap_trim = cfg_reg[TRIM_HI:TRIM_LO];
  assign eeprom_lock_n = cfg_reg[EEPROM_LOCK_BIT];
  assign program_lock_n = cfg_reg[PROGRAM_LOCK_BIT];
  assign brownout_enable = cfg_reg[BROWNOUT_EN_BIT];
  assign reset_pin_sel = cfg_reg[RESET_PIN_SEL_BIT];
  assign powerup_delay_en_n = cfg_reg[POWERUP_EN_N_BIT];
  assign watchdog_enable = cfg_reg[WATCHDOG_EN_BIT];
  // Decoded configuration
  assign clk_sel = cfg_reg[CLK_SEL_HI:0];
  assign xtal_mode = (clk_sel == CLK_XTAL) || (clk_sel == CLK_FAST_XTAL)
                   || (clk_sel == CLK_CODE_0 && CODE0_IS_XTAL);
  assign intrc_mode = (clk_sel == CLK_RC_QUARTER_CLOCK_OUT) || (clk_sel == CLK_RC_IO) || (clk_sel == CLK_INTERNAL_OSC_MODE_QUARTER_CLOCK_OUT)
                    || (clk_sel == CLK_CODE_4 && CODE4_IS_INTERNAL_OSC_MODE);
  assign ext_clk_mode = (clk_sel == CLK_EXT);
  assign delay_en = !cfg_reg[POWERUP_EN_N_BIT];
  assign settle_needed = xtal_mode;
  // Reset pin only counts when selected; otherwise tied inactive
  assign ext_reset = cfg_reg[RESET_PIN_SEL_BIT] && !pin_s;
  // Brown-out only acts when the detector is enabled
  assign brownout_reset_reg = cfg_reg[BROWNOUT_EN_BIT] && bo_s;
  // Configuration word access decode, programming mode only
  assign cfg_hit = pm_s && (PROG_ADDR == CFG_ADDR);
  assign cfg_wdata = PROG_WDATA & CFG_IMPL_MASK;
  // Configuration word: unprogrammed ones after reset, programmer rewrites it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_reg <= CFG_RESET;
    end else if (cfg_hit && PROG_WR) begin
      cfg_reg <= cfg_wdata;
    end
  end
  // Data erase pulse when data protection goes from enabled to disabled
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      EEPROM_ERASE <= 1'b0;
    end else begin
      EEPROM_ERASE <= cfg_hit && PROG_WR && !eeprom_lock_n && cfg_wdata[EEPROM_LOCK_BIT];
    end
  end
  // Program erase pulse when program protection goes from enabled to disabled
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PROGRAM_ERASE <= 1'b0;
    end else begin
      PROGRAM_ERASE <= cfg_hit && PROG_WR && !program_lock_n
                    && cfg_wdata[PROGRAM_LOCK_BIT];
    end
  end
  // Programmer read port; any address but the configuration word, or outside the mode, reads zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PROG_RDATA <= '0;
    end else if (cfg_hit && PROG_RD) begin
      PROG_RDATA <= cfg_reg;
    end else if (PROG_RD) begin
      PROG_RDATA <= '0;
    end
  end
  // Threshold trim output
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      BANDGAP_TRIM <= CFG_RESET[TRIM_HI:TRIM_LO];
    end else begin
      BANDGAP_TRIM <= bandgap_trim;
    end
  end
  // Brown-out detector enable output
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      BROWNOUT_ENABLE <= CFG_RESET[BROWNOUT_EN_BIT];
    end else begin
      BROWNOUT_ENABLE <= brownout_enable;
    end
  end
  // Watchdog enable output
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WATCHDOG_ENABLE <= CFG_RESET[WATCHDOG_EN_BIT];
    end else begin
      WATCHDOG_ENABLE <= watchdog_enable;
    end
  end
  // Oscillator select output
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CLOCK_SOURCE_SEL <= CFG_RESET[CLK_SEL_HI:0];
    end else begin
      CLOCK_SOURCE_SEL <= clk_sel;
    end
  end
  // Clock out function only in the two modes that route it to the pin
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      QUARTER_CLOCK_OUT_EN <= 1'b1;
    end else begin
      QUARTER_CLOCK_OUT_EN <= (clk_sel == CLK_RC_QUARTER_CLOCK_OUT) || (clk_sel == CLK_INTERNAL_OSC_MODE_QUARTER_CLOCK_OUT);
    end
  end
  // Data protection output
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      EEPROM_PROTECT <= 1'b0;
    end else begin
      EEPROM_PROTECT <= !eeprom_lock_n;
    end
  end
  // Program protection output
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PROGRAM_PROTECT <= 1'b0;
    end else begin
      PROGRAM_PROTECT <= !program_lock_n;
    end
  end
  // Timers: power-up delay then oscillator settle
  delay_counter #(.W(TW)) u_pu (
    .clk(CLK),
    .rst_n(RSTN),
    .clear(brownout_reset_reg),
    .t(pu_t)
  );
  delay_counter #(.W(TW)) u_os (
    .clk(CLK),
    .rst_n(RSTN),
    .clear(brownout_reset_reg),
    .t(os_t)
  );
  assign pu_t.load = TW'(POWERUP_CNT - 1);
  assign os_t.load = TW'(OSC_SETTLE_CNT - 1);
  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    pu_t.start = 1'b0;
    os_t.start = 1'b0;
    case (state_reg)
      ST_POR, ST_BROWNOUT: begin
        if (!brownout_reset_reg) begin
          if (delay_en) begin
            state_next = ST_POWERUP;
            pu_t.start = 1'b1;
          end else if (settle_needed) begin
            state_next = ST_SETTLE;
            os_t.start = 1'b1;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_POWERUP: begin
        if (brownout_reset_reg) begin
          state_next = ST_BROWNOUT;
        end else if (pu_t.done) begin
          if (settle_needed) begin
            state_next = ST_SETTLE;
            os_t.start = 1'b1;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_SETTLE: begin
        if (brownout_reset_reg) begin
          state_next = ST_BROWNOUT;
        end else if (os_t.done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (brownout_reset_reg) begin
          state_next = ST_BROWNOUT;
        end
      end
      default: begin
        state_next = ST_POR;
      end
    endcase
  end
  // Sequencer state
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end
  // Reset out: time-outs ignore the pin, pin only gates release
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CORE_RESET_N <= 1'b0;
    end else begin
      CORE_RESET_N <= (state_next == ST_RUN) && !ext_reset;
    end
  end
  // Oscillator stopped while external reset held in internal or RC mode
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      OSC_ENABLE <= 1'b1;
    end else begin
      OSC_ENABLE <= !(ext_reset && intrc_mode);
    end
  end
  // Power status register; brown-out clear wins over software set
  assign pwr_wr = REG_WR && (REG_ADDR == PWR_STATUS_ADDR);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      brownout_flag_reg <= 1'b0;
    end else if (brownout_reset_reg) begin
      brownout_flag_reg <= 1'b0;
    end else if (pwr_wr) begin
      brownout_flag_reg <= REG_WDATA[BROWNOUT_FLAG_BIT];
    end
  end
  // Power-on flag: cleared by power-on reset, written to either value by software
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      poweron_flag_reg <= 1'b0;
    end else if (pwr_wr) begin
      poweron_flag_reg <= REG_WDATA[POWERON_FLAG_BIT];
    end
  end
  // Core register read
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= '0;
    end else if (REG_ADDR == PWR_STATUS_ADDR) begin
      REG_RDATA <= {6'h00, poweron_flag_reg, brownout_flag_reg};
    end else begin
      REG_RDATA <= '0;
    end
  end
endmodule : reset_config_sequencer

// ==== sim/reset_config_sequencer_assertions.sv ====
`timescale 1ns/1ps
module reset_config_sequencer_assertions (
  input wire logic CLK, // Clock
  input wire logic RSTN, // Reset, low
  input wire logic PROG_RD, // Read strobe
  input wire logic [13:0] PROG_ADDR, // Address
  input wire logic BROWNOUT_DETECT, // Supply low
  input wire logic REG_WR, // Core write
  input wire logic [7:0] REG_ADDR, // Core address
  input wire logic [7:0] REG_WDATA, // Core data
  input wire logic [13:0] PROG_RDATA, // Read data
  input wire logic [7:0] REG_RDATA, // Status read
  input wire logic CORE_RESET_N, // Device reset
  input wire logic OSC_ENABLE, // Oscillator run
  input wire logic BROWNOUT_ENABLE, // Detector on
  input wire logic [2:0] CLOCK_SOURCE_SEL, // Oscillator kind
  input wire logic QUARTER_CLOCK_OUT_EN, // Clock out
  input wire logic EEPROM_PROTECT, // Data protection
  input wire logic PROGRAM_PROTECT, // Program protection
  input wire logic EEPROM_ERASE, // Data erase
  input wire logic PROGRAM_ERASE // Program erase
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Status write of bit 1, and a sustained dip while the status is addressed
  sequence s_set_por;
    (REG_WR && REG_ADDR == 8'h8e && REG_WDATA[1]) ##1 (REG_ADDR == 8'h8e);
  endsequence
  sequence s_dip;
    (BROWNOUT_DETECT && BROWNOUT_ENABLE) [*4] ##0 (REG_ADDR == 8'h8e);
  endsequence
  a_eeprom_erase_drop: assert property (EEPROM_ERASE |-> EEPROM_PROTECT ##1 !EEPROM_PROTECT)
    else $error("data erase without protection drop");
  a_program_erase_drop: assert property (PROGRAM_ERASE |-> PROGRAM_PROTECT ##1 !PROGRAM_PROTECT)
    else $error("program erase without protection drop");
  a_osc_stop_mode: assert property (!OSC_ENABLE |-> CLOCK_SOURCE_SEL inside {3'h7, 3'h6, 3'h5, 3'h4})
    else $error("oscillator stopped in wrong mode");
  a_clock_out_sel: assert property (QUARTER_CLOCK_OUT_EN == (CLOCK_SOURCE_SEL inside {3'h7, 3'h5}))
    else $error("clock out select wrong");
  a_dip_holds_reset: assert property ((BROWNOUT_DETECT && BROWNOUT_ENABLE) [*4] |=> !CORE_RESET_N)
    else $error("core left running during dip");
  a_bad_addr_read: assert property (PROG_RD && PROG_ADDR != 14'h2007 |=> PROG_RDATA == 14'h0000)
    else $error("read outside config word not zero");
  a_status_upper_zero: assert property (REG_RDATA[7:2] == 6'h00)
    else $error("status upper bits set");
  a_status_por_set: assert property (s_set_por |=> REG_RDATA[1])
    else $error("power-on flag not set by write");
  a_status_dip_clear: assert property (s_dip |=> !REG_RDATA[0])
    else $error("brown-out flag not cleared");
endmodule : reset_config_sequencer_assertions

bind reset_config_sequencer reset_config_sequencer_assertions chk_i (.CLK, .RSTN, .PROG_RD, .PROG_ADDR,
  .BROWNOUT_DETECT, .REG_WR, .REG_ADDR, .REG_WDATA, .PROG_RDATA, .REG_RDATA, .CORE_RESET_N, .OSC_ENABLE,
  .BROWNOUT_ENABLE, .CLOCK_SOURCE_SEL, .QUARTER_CLOCK_OUT_EN, .EEPROM_PROTECT, .PROGRAM_PROTECT,
  .EEPROM_ERASE, .PROGRAM_ERASE);

// ==== sim/prog_supply_model.sv ====
`timescale 1ns/1ps
module prog_supply_model (
  input wire logic clk, // Clock
  output logic mode, // Programming mode
  output logic wr, // Write strobe
  output logic rd, // Read strobe
  output logic [13:0] addr, // Address
  output logic [13:0] wdata, // Write data
  input wire logic [13:0] rdata, // Read data
  output logic dip, // Supply below threshold
  output logic pin_n // Reset pin level
);
  // Idle levels
  initial begin
    {mode, wr, rd, dip, pin_n} = 5'b10001;
    addr = 14'h0000;
    wdata = 14'h0000;
  end
  // Write keeps factory trim; data lines scrambled once released
  task automatic prog_write(input logic [13:0] a, input logic [13:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= {2'b11, d[11:0]};
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : prog_write
  // Read strobe, data taken one edge later
  task automatic prog_read(input logic [13:0] a, output logic [13:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : prog_read
  // Supply below threshold for n cycles
  task automatic supply_dip(input int n);
    @(posedge clk);
    dip <= 1'b1;
    repeat (n) @(posedge clk);
    dip <= 1'b0;
  endtask : supply_dip
  // Programming mode and reset pin levels
  task automatic set_lines(input logic m, input logic p);
    @(posedge clk);
    mode <= m;
    pin_n <= p;
  endtask : set_lines
endmodule : prog_supply_model

// ==== sim/reset_config_sequencer_test.sv ====
`timescale 1ns/1ps
module reset_config_sequencer_test;
  import rcs_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, mode, wr, rd, dip, pin_n, core_n, osc_en, bo_en, wd_en, ep, pp, ee, pe;
  logic qco;
  logic [7:0] reg_addr = 8'h8e, reg_wdata = 8'h00, rrdata;
  logic [13:0] addr, wdata, prdata, rd14, cfg_m;
  logic [1:0] trim;
  logic [2:0] csel;
  logic [31:0] seed = 32'hbbd84b91;
  logic [13:0] tcfg [4] = '{14'h31e9, 14'h31fb, 14'h31f8, 14'h31eb};
  int tlo [4] = '{28, 0, 8, 20};
  int n_fail = 0, tests_run = 0, cyc = 0, n_ee = 0, n_pe = 0, e_ee = 0, e_pe = 0, n;
  always #12.5 clk = ~clk;
  prog_supply_model p (.clk(clk), .mode(mode), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(prdata),
    .dip(dip), .pin_n(pin_n));
  reset_config_sequencer #(.POWERUP_CNT(20), .OSC_SETTLE_CNT(8)) dut (.CLK(clk), .RSTN(rstn), .PROG_MODE(mode),
    .PROG_WR(wr), .PROG_RD(rd), .PROG_ADDR(addr), .PROG_WDATA(wdata), .BROWNOUT_DETECT(dip),
    .EXT_RESET_PIN_N(pin_n), .REG_WR(reg_wr), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .PROG_RDATA(prdata),
    .REG_RDATA(rrdata), .CORE_RESET_N(core_n), .OSC_ENABLE(osc_en), .BANDGAP_TRIM(trim), .BROWNOUT_ENABLE(bo_en),
    .WATCHDOG_ENABLE(wd_en), .CLOCK_SOURCE_SEL(csel), .QUARTER_CLOCK_OUT_EN(qco), .EEPROM_PROTECT(ep),
    .PROGRAM_PROTECT(pp), .EEPROM_ERASE(ee), .PROGRAM_ERASE(pe));
  task automatic stop_test;
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // Erase pulse counters and hang limit
  always @(posedge clk) begin
    cyc++;
    n_ee += ee;
    n_pe += pe;
    if (cyc == 5000) begin
      n_fail++;
      stop_test;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Decoded configuration against the model
  task automatic dec_chk;
    repeat (2) @(posedge clk);
    #1 chk(trim, cfg_m[13:12]);
    chk(ep, !cfg_m[8]);
    chk(pp, !cfg_m[7]);
    chk(bo_en, cfg_m[6]);
    chk(wd_en, cfg_m[3]);
    chk(csel, cfg_m[2:0]);
    chk(qco, cfg_m[2:0] == 3'h7 || cfg_m[2:0] == 3'h5);
  endtask : dec_chk
  // Programmer write, model update, decode and read-back
  task automatic cfg_write(input logic [13:0] d);
    d = {2'b11, d[11:0]} & CFG_IMPL_MASK;
    e_ee += (!cfg_m[8] && d[8]);
    e_pe += (!cfg_m[7] && d[7]);
    cfg_m = d;
    p.prog_write(14'h2007, d);
    dec_chk;
    p.prog_read(14'h2007, rd14);
    chk(rd14, cfg_m);
  endtask : cfg_write
  task automatic reg_write(input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : reg_write
  // Dip the supply, then count cycles until the core runs
  task automatic dip_count(input int len);
    p.supply_dip(len);
    #1 chk(core_n, 1'b0);
    n = 0;
    while (core_n !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : dip_count
  // Main sequence
  initial begin
    cfg_m = 14'h31ff;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    dec_chk;
    chk(rrdata[1], 1'b0);
    p.prog_read(14'h2006, rd14);
    chk(rd14, 14'h0000);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      cfg_write(seed[13:0]);
    end
    cfg_write(14'h307f);
    cfg_write(14'h31ff);
    chk(14'(n_ee), 14'(e_ee));
    chk(14'(n_pe), 14'(e_pe));
    p.prog_write(14'h2006, 14'h0000);
    p.set_lines(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    p.prog_write(14'h2007, 14'h0000);
    p.set_lines(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    p.prog_read(14'h2007, rd14);
    chk(rd14, cfg_m);
    reg_write(8'hff);
    chk(rrdata, 8'h03);
    for (int i = 0; i < 4; i++) begin
      cfg_write(tcfg[i]);
      dip_count(4 + i);
      chk(n >= tlo[i] && n <= tlo[i] + 6, 1'b1);
      chk(rrdata, 8'h02);
    end
    p.supply_dip(4);
    repeat (10) @(posedge clk);
    dip_count(4);
    chk(n >= 20 && n <= 26, 1'b1);
    cfg_write(14'h31ec);
    p.set_lines(1'b1, 1'b0);
    p.supply_dip(4);
    repeat (40) @(posedge clk);
    #1 chk(core_n, 1'b0);
    chk(osc_en, 1'b0);
    p.set_lines(1'b1, 1'b1);
    repeat (5) @(posedge clk);
    #1 chk(core_n, 1'b1);
    cfg_write(14'h31df);
    p.set_lines(1'b1, 1'b0);
    repeat (5) @(posedge clk);
    #1 chk({core_n, osc_en}, 2'b11);
    p.set_lines(1'b1, 1'b1);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cfg_m = 14'h31ff;
    repeat (4) @(posedge clk);
    dec_chk;
    chk(rrdata[1], 1'b0);
    stop_test;
  end
endmodule : reset_config_sequencer_test
